// ==== rtl/rid_defs.svh ====
/*
 * Constants of the instruction decoder: word encodings, special file
 * addresses, field positions and reset values.
 * Assumes inclusion by the design modules; the package does not include it.
 */
`ifndef RID_DEFS_SVH
`define RID_DEFS_SVH

`define RID_WORD_IDLE 14'h0000
`define RID_WORD_RETURN 14'h0008
`define RID_WORD_INT_EXIT 14'h0009
`define RID_WORD_KICK 14'h0064
`define RID_WORD_SLEEP 14'h0063
`define RID_ADDR_TIMER 7'h01
`define RID_ADDR_PORT_A 7'h05
`define RID_ADDR_PORT_B 7'h06
`define RID_GRP_MSB 13
`define RID_GRP_LSB 12
`define RID_OP_MSB 11
`define RID_OP_LSB 8
`define RID_DEST_BIT 7
`define RID_BIT_MSB 9
`define RID_BIT_LSB 7
`define RID_ADDR_MSB 6
`define RID_RST_PC 11'h000
`define RID_RST_TO 1'b1
`define RID_RST_PD 1'b1

`endif

// ==== rtl/rid_pkg.sv ====
/*
 * Types shared by the instruction decoder modules.
 * Assumes the constants header is on the include path.
 */
package rid_pkg;
    typedef enum logic [1:0] {
        RID_Q1 = 2'b00,
        RID_Q2 = 2'b01,
        RID_Q3 = 2'b11,
        RID_Q4 = 2'b10
    } rid_phase_type;

    typedef struct packed {
        rid_phase_type phase;
        logic [10:0] pc;
        logic [13:0] ir;
        logic skip;
        logic [6:0] rf_addr;
        logic [7:0] opnd;
        logic [7:0] res;
        logic rf_we;
        logic [7:0] acc;
        logic c;
        logic dc;
        logic z;
        logic to;
        logic pd;
        logic [2:0] sp;
        logic [7:0][10:0] stk;
        logic gie;
        logic asleep;
        logic wdt_kick;
        logic presc_clr;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pin_v;
    } rid_state_type;
endpackage

// ==== rtl/rid_alu.sv ====
/*
 * Data path of the decoder: arithmetic, logic, bit and literal results,
 * flag values, write targets and skip conditions for one word.
 * Assumes the operand was read already; purely combinational.
 */
`timescale 1ns/1ps
`include "rid_defs.svh"

module rid_alu
    import rid_pkg::*;
(
    // Instruction and operands.
    input wire logic [13:0] ir_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] opnd_i,
    input wire logic carry_i,
    // Results.
    output logic [7:0] result_o,
    output logic carry_o,
    output logic dcarry_o,
    output logic zero_o,
    output logic wr_acc_o,
    output logic wr_file_o,
    output logic upd_c_o,
    output logic upd_dc_o,
    output logic upd_z_o,
    output logic skip_o
);
    function automatic logic [8:0] add_fn(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic cin);
        add_fn = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    function automatic logic nib_carry(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        nib_carry = s[4];
    endfunction

    logic [8:0] sum;
    logic [7:0] mask;
    logic [3:0] op;
    logic dest;
    logic [7:0] lit;

    assign op = ir_i[`RID_OP_MSB:`RID_OP_LSB];
    assign dest = ir_i[`RID_DEST_BIT];
    assign lit = ir_i[7:0];
    assign mask = 8'h01 << ir_i[`RID_BIT_MSB:`RID_BIT_LSB];

    always_comb begin
        sum = 9'h000;
        result_o = 8'h00;
        carry_o = carry_i;
        dcarry_o = 1'b0;
        wr_acc_o = 1'b0;
        wr_file_o = 1'b0;
        upd_c_o = 1'b0;
        upd_dc_o = 1'b0;
        upd_z_o = 1'b0;
        skip_o = 1'b0;
        unique case (ir_i[`RID_GRP_MSB:`RID_GRP_LSB])
            2'b00: begin
                wr_acc_o = !dest;
                wr_file_o = dest;
                unique case (op)
                    4'h0: begin
                        result_o = acc_i;
                        wr_acc_o = 1'b0;
                    end
                    4'h1: begin
                        result_o = 8'h00;
                        upd_z_o = 1'b1;
                    end
                    4'h2: begin
                        sum = add_fn(opnd_i, ~acc_i, 1'b1);
                        dcarry_o = nib_carry(opnd_i, ~acc_i, 1'b1);
                    end
                    4'h3: begin
                        result_o = opnd_i - 8'h01;
                        upd_z_o = 1'b1;
                    end
                    4'h4: begin
                        result_o = opnd_i | acc_i;
                        upd_z_o = 1'b1;
                    end
                    4'h5: begin
                        result_o = opnd_i & acc_i;
                        upd_z_o = 1'b1;
                    end
                    4'h6: begin
                        result_o = opnd_i ^ acc_i;
                        upd_z_o = 1'b1;
                    end
                    4'h7: begin
                        sum = add_fn(opnd_i, acc_i, 1'b0);
                        dcarry_o = nib_carry(opnd_i, acc_i, 1'b0);
                    end
                    4'h8: begin
                        result_o = opnd_i;
                        upd_z_o = 1'b1;
                    end
                    4'h9: begin
                        result_o = ~opnd_i;
                        upd_z_o = 1'b1;
                    end
                    4'ha: begin
                        result_o = opnd_i + 8'h01;
                        upd_z_o = 1'b1;
                    end
                    4'hb: begin
                        result_o = opnd_i - 8'h01;
                        skip_o = (result_o == 8'h00);
                    end
                    4'hc: begin
                        result_o = {carry_i, opnd_i[7:1]};
                        carry_o = opnd_i[0];
                        upd_c_o = 1'b1;
                    end
                    4'hd: begin
                        result_o = {opnd_i[6:0], carry_i};
                        carry_o = opnd_i[7];
                        upd_c_o = 1'b1;
                    end
                    4'he: result_o = {opnd_i[3:0], opnd_i[7:4]};
                    4'hf: begin
                        result_o = opnd_i + 8'h01;
                        skip_o = (result_o == 8'h00);
                    end
                endcase
                if (op == 4'h2 || op == 4'h7) begin
                    result_o = sum[7:0];
                    carry_o = sum[8];
                    upd_c_o = 1'b1;
                    upd_dc_o = 1'b1;
                    upd_z_o = 1'b1;
                end
            end
            2'b01: begin
                unique case (ir_i[11:10])
                    2'b00: begin
                        result_o = opnd_i & ~mask;
                        wr_file_o = 1'b1;
                    end
                    2'b01: begin
                        result_o = opnd_i | mask;
                        wr_file_o = 1'b1;
                    end
                    2'b10: skip_o = ((opnd_i & mask) == 8'h00);
                    2'b11: skip_o = ((opnd_i & mask) != 8'h00);
                endcase
            end
            2'b10: result_o = 8'h00;
            2'b11: begin
                wr_acc_o = 1'b1;
                unique case (op)
                    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
                        result_o = lit;
                    4'h8: result_o = lit | acc_i;
                    4'h9: result_o = lit & acc_i;
                    4'ha: result_o = lit ^ acc_i;
                    4'hb: wr_acc_o = 1'b0;
                    4'hc, 4'hd: begin
                        sum = add_fn(lit, ~acc_i, 1'b1);
                        dcarry_o = nib_carry(lit, ~acc_i, 1'b1);
                    end
                    4'he, 4'hf: begin
                        sum = add_fn(lit, acc_i, 1'b0);
                        dcarry_o = nib_carry(lit, acc_i, 1'b0);
                    end
                endcase
                upd_z_o = (op[3] && op != 4'hb);
                if (op[3:2] == 2'b11) begin
                    result_o = sum[7:0];
                    carry_o = sum[8];
                    upd_c_o = 1'b1;
                    upd_dc_o = 1'b1;
                end
            end
        endcase
        zero_o = (result_o == 8'h00);
    end
endmodule

// ==== rtl/rid_core.sv ====
/*
 * Four-phase sequencer and control decoder of the 14-bit core: fetch,
 * operand read, execute, write back, program counter and stack.
 * Assumes program memory and register file answer combinationally in
 * the same clock domain, and that port pins come from outside.
 */
// Behaviour
// - One cycle per word; taken skips and flow changes add an idle cycle.
// - Each instruction cycle spans four clock periods.
// - Rotate left and right through carry, updating only carry.
// - Byte decode; logic ops set zero, add and subtract set all flags.
// - Decrement or increment, skip next on zero, flags unchanged.
// - Bit words clear, set, or skip on clear or set.
// - Return, interrupt exit and literal return take two cycles.
// - Watchdog kick clears the dog and sets both status bits.
// - Sleep enters standby, sets timeout and clears powerdown.
// - Literal OR, AND, XOR affect zero; literal load affects nothing.
// - Literal add and subtract write accumulator and all three flags.
// - Read-modify-write of a port uses pin levels.
// - Writing the timer clears the prescaler when assigned to it.
// - Destination zero writes accumulator, one writes the file.
// - File address is seven bits, 0x00 to 0x7f.
`timescale 1ns/1ps
`include "rid_defs.svh"

module rid_core
    import rid_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Program memory.
    output logic [10:0] pm_addr_o,
    input wire logic [13:0] pm_data_i,
    // Register file.
    output logic [6:0] rf_addr_o,
    input wire logic [7:0] rf_rdata_i,
    output logic [7:0] rf_wdata_o,
    output logic rf_we_o,
    // Port pins and timer.
    input wire logic [7:0] pin_i,
    input wire logic presc_timer_i,
    output logic presc_clr_o,
    // Core status.
    input wire logic wake_i,
    output logic [7:0] acc_o,
    output logic status_c_o,
    output logic status_dc_o,
    output logic status_z_o,
    output logic timeout_status_bit_o,
    output logic powerdown_status_bit_o,
    output logic wdt_kick_o,
    output logic sleep_o,
    output logic gie_o
);
    function automatic logic is_port(input logic [6:0] a);
        is_port = (a == `RID_ADDR_PORT_A) || (a == `RID_ADDR_PORT_B);
    endfunction

    rid_state_type s_q;
    rid_state_type s_d;
    logic [7:0] alu_res;
    logic alu_c, alu_dc, alu_z, wr_acc, wr_file;
    logic upd_c, upd_dc, upd_z, alu_skip;
    logic is_ret, is_call, is_jump;
    logic [10:0] ir_k;
    logic [2:0] sp_dn;

    rid_alu u_alu (
        .ir_i(s_q.ir),
        .acc_i(s_q.acc),
        .opnd_i(s_q.opnd),
        .carry_i(s_q.c),
        .result_o(alu_res),
        .carry_o(alu_c),
        .dcarry_o(alu_dc),
        .zero_o(alu_z),
        .wr_acc_o(wr_acc),
        .wr_file_o(wr_file),
        .upd_c_o(upd_c),
        .upd_dc_o(upd_dc),
        .upd_z_o(upd_z),
        .skip_o(alu_skip)
    );

    assign ir_k = s_q.ir[10:0];
    assign sp_dn = s_q.sp - 3'h1;
    assign is_ret = (s_q.ir == `RID_WORD_RETURN) ||
                    (s_q.ir == `RID_WORD_INT_EXIT) ||
                    (s_q.ir[13:10] == 4'b1101);
    assign is_call = (s_q.ir[13:11] == 3'b100);
    assign is_jump = (s_q.ir[13:11] == 3'b101);

    always_comb begin
        s_d = s_q;
        // Three-stage pin capture; a change counts once the last two stages agree.
        s_d.pin_s1 = pin_i;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_s3 = s_q.pin_s2;
        if (s_q.pin_s2 == s_q.pin_s3) begin
            s_d.pin_v = s_q.pin_s3;
        end
        unique case (s_q.phase)
            RID_Q1: begin
                s_d.rf_addr = s_q.ir[`RID_ADDR_MSB:0];
                s_d.wdt_kick = 1'b0;
                // Sleep parks the sequencer here so no write is half done.
                if (!s_q.asleep || wake_i) begin
                    s_d.asleep = 1'b0;
                    s_d.phase = RID_Q2;
                end
            end
            RID_Q2: begin
                // port operands come from the pins.
                s_d.opnd = is_port(s_q.rf_addr) ? s_q.pin_v : rf_rdata_i;
                s_d.phase = RID_Q3;
            end
            RID_Q3: begin
                s_d.res = alu_res;
                s_d.rf_we = wr_file;
                s_d.skip = alu_skip;
                if (wr_acc) begin
                    s_d.acc = alu_res;
                end
                if (upd_c) begin
                    s_d.c = alu_c;
                end
                if (upd_dc) begin
                    s_d.dc = alu_dc;
                end
                if (upd_z) begin
                    s_d.z = alu_z;
                end
                s_d.presc_clr = wr_file && presc_timer_i &&
                                (s_q.rf_addr == `RID_ADDR_TIMER);
                s_d.phase = RID_Q4;
            end
            RID_Q4: begin
                s_d.rf_we = 1'b0;
                s_d.presc_clr = 1'b0;
                s_d.pc = s_q.pc + 11'h001;
                s_d.ir = pm_data_i;
                if (s_q.ir == `RID_WORD_KICK) begin
                    s_d.wdt_kick = 1'b1;
                    s_d.to = 1'b1;
                    s_d.pd = 1'b1;
                end
                if (s_q.ir == `RID_WORD_SLEEP) begin
                    s_d.asleep = 1'b1;
                    s_d.to = 1'b1;
                    s_d.pd = 1'b0;
                end
                if (is_call) begin
                    s_d.stk[s_q.sp] = s_q.pc;
                    s_d.sp = s_q.sp + 3'h1;
                end
                if (is_call || is_jump) begin
                    s_d.pc = ir_k;
                end
                if (is_ret) begin
                    s_d.pc = s_q.stk[sp_dn];
                    s_d.sp = sp_dn;
                end
                if (s_q.ir == `RID_WORD_INT_EXIT) begin
                    s_d.gie = 1'b1;
                end
                if (s_q.skip || is_call || is_jump || is_ret) begin
                    s_d.ir = `RID_WORD_IDLE;
                end
                s_d.phase = RID_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.pc <= `RID_RST_PC;
            s_q.to <= `RID_RST_TO;
            s_q.pd <= `RID_RST_PD;
        end else begin
            s_q <= s_d;
        end
    end

    assign pm_addr_o = s_q.pc;
    assign rf_addr_o = s_q.rf_addr;
    assign rf_wdata_o = s_q.res;
    assign rf_we_o = s_q.rf_we;
    assign presc_clr_o = s_q.presc_clr;
    assign acc_o = s_q.acc;
    assign status_c_o = s_q.c;
    assign status_dc_o = s_q.dc;
    assign status_z_o = s_q.z;
    assign timeout_status_bit_o = s_q.to;
    assign powerdown_status_bit_o = s_q.pd;
    assign wdt_kick_o = s_q.wdt_kick;
    assign sleep_o = s_q.asleep;
    assign gie_o = s_q.gie;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_phase_walk: assert property (
        s_q.phase == RID_Q1 && !s_q.asleep |=> s_q.phase == RID_Q2
        ##1 s_q.phase == RID_Q3 ##1 s_q.phase == RID_Q4 ##1
        s_q.phase == RID_Q1) else $error("phase order broken");
    a_skip_idle: assert property (
        s_q.phase == RID_Q4 && s_q.skip |=> s_q.ir == `RID_WORD_IDLE)
        else $error("skipped word not replaced by idle");
    a_file_dest: assert property (
        s_q.phase == RID_Q3 && s_q.ir[13:12] == 2'b00 &&
        s_q.ir[11:8] == 4'h7 |=> s_q.rf_we == $past(s_q.ir[7]))
        else $error("destination select not honoured");
    a_acc_add: assert property (
        s_q.phase == RID_Q3 && s_q.ir[13:8] == 6'h07 |=>
        s_q.z == ($past(s_q.acc + s_q.opnd) == 8'h00) &&
        s_q.acc == ($past(s_q.ir[7]) ? $past(s_q.acc) :
        $past(s_q.acc + s_q.opnd)))
        else $error("add to accumulator wrong");
    a_jump_target: assert property (
        s_q.phase == RID_Q4 && is_jump |=> s_q.pc == $past(ir_k))
        else $error("jump target not loaded");
    a_kick_bits: assert property (
        s_q.phase == RID_Q4 && s_q.ir == `RID_WORD_KICK |=>
        s_q.wdt_kick && s_q.to && s_q.pd ##1 !s_q.wdt_kick)
        else $error("watchdog kick wrong");
    a_sleep_bits: assert property (
        s_q.phase == RID_Q4 && s_q.ir == `RID_WORD_SLEEP |=>
        s_q.asleep && s_q.to && !s_q.pd)
        else $error("sleep status wrong");
    a_presc_cause: assert property (
        s_q.presc_clr |-> s_q.rf_we && s_q.rf_addr == `RID_ADDR_TIMER
        ##1 !s_q.presc_clr) else $error("prescaler clear without cause");
    a_pin_source: assert property (
        s_q.phase == RID_Q2 && is_port(s_q.rf_addr) |=>
        s_q.opnd == $past(s_q.pin_v)) else $error("port read not from pins");
endmodule

// ==== verif/rid_mem_model.sv ====
/*
 * Behavioural program memory and register file facing the decoder core.
 * Assumes the bench loads both arrays while the core is held in reset.
 */
`timescale 1ns/1ps

module rid_mem_model (
    // Clock.
    input wire logic clk_i,
    // Program memory.
    input wire logic [10:0] pm_addr_i,
    output logic [13:0] pm_data_o,
    // Register file.
    input wire logic [6:0] rf_addr_i,
    output logic [7:0] rf_rdata_o,
    input wire logic [7:0] rf_wdata_i,
    input wire logic rf_we_i
);
    logic [13:0] prog [2048];
    logic [7:0] regs [128];

    // Both answer combinationally, so the core sees no wait states.
    assign pm_data_o = prog[pm_addr_i];
    assign rf_rdata_o = regs[rf_addr_i];

    always @(posedge clk_i) begin
        if (rf_we_i === 1'b1) begin
            regs[rf_addr_i] <= rf_wdata_i;
        end
    end
endmodule

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench: short programs run from the memory model and the
 * results are judged at the core's ports and in the register file.
 * Assumes core and memory model share one 25 MHz clock.
 */
`timescale 1ns/1ps

module tb_top;
    import rid_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [10:0] pm_addr_o;
    logic [13:0] pm_data_i;
    logic [6:0] rf_addr_o;
    logic [7:0] rf_rdata_i, rf_wdata_o, acc_o;
    logic [7:0] pin_i = 8'h00;
    logic presc_timer_i = 1'b0;
    logic wake_i = 1'b0;
    logic rf_we_o, presc_clr_o, status_c_o, status_dc_o, status_z_o;
    logic timeout_status_bit_o, powerdown_status_bit_o;
    logic wdt_kick_o, sleep_o, gie_o;
    int bad_count = 0;
    int samples_checked = 0;
    int edge_n = 0;
    int kick_n = 0;
    int clr_n = 0;
    int we_t[$];
    logic [7:0] we_d[$];
    logic [13:0] code[$];

    rid_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .pm_addr_o(pm_addr_o),
        .pm_data_i(pm_data_i), .rf_addr_o(rf_addr_o),
        .rf_rdata_i(rf_rdata_i), .rf_wdata_o(rf_wdata_o),
        .rf_we_o(rf_we_o), .pin_i(pin_i), .presc_timer_i(presc_timer_i),
        .presc_clr_o(presc_clr_o), .wake_i(wake_i), .acc_o(acc_o),
        .status_c_o(status_c_o), .status_dc_o(status_dc_o),
        .status_z_o(status_z_o),
        .timeout_status_bit_o(timeout_status_bit_o),
        .powerdown_status_bit_o(powerdown_status_bit_o),
        .wdt_kick_o(wdt_kick_o), .sleep_o(sleep_o), .gie_o(gie_o));

    rid_mem_model i_mem (.clk_i(clk_i), .pm_addr_i(pm_addr_o),
        .pm_data_o(pm_data_i), .rf_addr_i(rf_addr_o),
        .rf_rdata_o(rf_rdata_i), .rf_wdata_i(rf_wdata_o),
        .rf_we_i(rf_we_o));

    always #20 clk_i = ~clk_i;

    always @(posedge clk_i) edge_n++;

    // Pulses stand one clock, so the falling edge sees each exactly once.
    always @(negedge clk_i) begin
        if (rf_we_o === 1'b1 && rf_addr_o === 7'h30) begin
            we_t.push_back(edge_n);
            we_d.push_back(rf_wdata_o);
        end
        if (wdt_kick_o === 1'b1) kick_n++;
        if (presc_clr_o === 1'b1) clr_n++;
    end

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_num(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Memories are cleared in reset so no word of an earlier run leaks in.
    task automatic boot();
        @(posedge clk_i);
        rst_i <= 1'b1;
        for (int a = 0; a < 2048; a++) i_mem.prog[a] = 14'h0000;
        for (int a = 0; a < 128; a++) i_mem.regs[a] = 8'h00;
        foreach (code[a]) i_mem.prog[a] = code[a];
    endtask

    task automatic go(input int n);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        kick_n = 0;
        clr_n = 0;
        we_t.delete();
        we_d.delete();
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic sc_literal();
        code = '{14'h3015, 14'h3e10, 14'h3cff, 14'h3801, 14'h395f,
                 14'h3a5b, 14'h2806};
        boot();
        @(negedge clk_i);
        check_val(acc_o, 8'h00); // RESET
        check_bit(timeout_status_bit_o, 1'b1); // RESET
        check_bit(powerdown_status_bit_o, 1'b1); // RESET
        check_val(pm_addr_o[7:0], 8'h00); // RESET
        go(60);
        check_val(acc_o, 8'h00);
        check_bit(status_z_o, 1'b1);
        check_bit(status_c_o, 1'b1);
        check_bit(status_dc_o, 1'b1);
    endtask

    task automatic sc_byte();
        code = '{14'h300f, 14'h07a0, 14'h0d20, 14'h02ff, 14'h0ba1,
                 14'h30ee, 14'h0ca0, 14'h01a2, 14'h2808};
        boot();
        i_mem.regs[7'h20] = 8'h81;
        i_mem.regs[7'h7f] = 8'h02;
        i_mem.regs[7'h21] = 8'h01;
        i_mem.regs[7'h22] = 8'h55;
        go(80);
        check_val(acc_o, 8'h20);
        check_val(i_mem.regs[7'h20], 8'h48);
        check_val(i_mem.regs[7'h7f], 8'he2);
        check_val(i_mem.regs[7'h21], 8'h00);
        check_val(i_mem.regs[7'h22], 8'h00);
        check_bit(status_c_o, 1'b0);
        check_bit(status_dc_o, 1'b1);
        check_bit(status_z_o, 1'b1);
    endtask

    // The skipped load would leave a nonzero sum if the skip failed.
    task automatic sc_byte_more();
        code = '{14'h30f0, 14'h0520, 14'h06a0, 14'h0fa1, 14'h3055,
                 14'h0722, 14'h2806};
        boot();
        i_mem.regs[7'h20] = 8'h3c;
        i_mem.regs[7'h21] = 8'hff;
        i_mem.regs[7'h22] = 8'hd0;
        go(60);
        check_val(acc_o, 8'h00);
        check_val(i_mem.regs[7'h20], 8'h0c);
        check_val(i_mem.regs[7'h21], 8'h00);
        check_bit(status_c_o, 1'b1);
        check_bit(status_z_o, 1'b1);
    endtask

    task automatic sc_bits();
        code = '{14'h1430, 14'h1c30, 14'h1030, 14'h14b0, 14'h1930,
                 14'h17b0, 14'h2008, 14'h2807, 14'h1030, 14'h0008};
        boot();
        go(120);
        check_num(we_t.size(), 3);
        if (we_t.size() == 3) begin
            check_num(we_t[1] - we_t[0], 12);
            check_num(we_t[2] - we_t[1], 20);
            check_val(we_d[0], 8'h01);
            check_val(we_d[1], 8'h03);
            check_val(we_d[2], 8'h02);
        end
    endtask

    task automatic sc_control();
        code = '{14'h2005, 14'h2006, 14'h0064, 14'h0063, 14'h2804,
                 14'h0009, 14'h343c};
        boot();
        go(80);
        check_val(acc_o, 8'h3c);
        check_bit(gie_o, 1'b1);
        check_num(kick_n, 1);
        check_bit(sleep_o, 1'b1);
        check_bit(timeout_status_bit_o, 1'b1);
        check_bit(powerdown_status_bit_o, 1'b0);
        @(posedge clk_i);
        wake_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        wake_i <= 1'b0;
        @(negedge clk_i);
        check_bit(sleep_o, 1'b0);
    endtask

    task automatic sc_port();
        code = '{14'h0486, 14'h0181, 14'h00a1, 14'h2803};
        boot();
        pin_i <= 8'h0f;
        presc_timer_i <= 1'b1;
        i_mem.regs[7'h06] = 8'hff;
        i_mem.regs[7'h01] = 8'h33;
        i_mem.regs[7'h21] = 8'h77;
        go(40);
        check_val(i_mem.regs[7'h06], 8'h0f);
        check_val(i_mem.regs[7'h01], 8'h00);
        check_num(clr_n, 1);
        check_val(i_mem.regs[7'h21], 8'h00);
    endtask

    initial begin
        sc_literal();
        sc_byte();
        sc_byte_more();
        sc_bits();
        sc_control();
        sc_port();
        test_done();
    end

    // The whole run needs well under a thousand clocks.
    initial begin
        #160000;
        bad_count++;
        test_done();
    end
endmodule
